// file: src/ppc_pkg.sv
/*
 * Shared constants for the port crossbar: config bit positions,
 * function slots in priority order, reset values.
 * Assumes 4 ports of 8 pins and one system clock.
 */
package ppc_pkg;
    localparam int PINS = 32;
    localparam int FNS = 35;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [31:0] LATCH_RST = 32'hffffffff;
    // cfg_a bits
    localparam int A_TW = 0;
    localparam int A_SS = 1;
    localparam int A_SA = 2;
    localparam int A_ARR_LO = 3;
    localparam int A_ECLK = 6;
    localparam int A_CMPA = 7;
    // cfg_b bits
    localparam int B_CMPB = 0;
    localparam int B_TMRA = 1;
    localparam int B_IRQA = 2;
    localparam int B_TMRB = 3;
    localparam int B_IRQB = 4;
    localparam int B_TMRC = 5;
    localparam int B_TMRCX = 6;
    localparam int B_CLKO = 7;
    // cfg_c bits
    localparam int C_CONVA = 0;
    localparam int C_TMREX = 1;
    localparam int C_SB = 2;
    localparam int C_TMRE = 3;
    localparam int C_XBAR = 4;
    localparam int C_MEMLO = 5;
    localparam int C_PUD = 7;
    // cfg_d bits
    localparam int D_TMRD = 0;
    localparam int D_TMRDX = 1;
    localparam int D_CONVC = 2;
    localparam int D_CMPC = 3;
    // function slots, highest priority first
    localparam int FN_SA_TX = 0;
    localparam int FN_SA_RX = 1;
    localparam int FN_SS_CLK = 2;
    localparam int FN_SS_SEL = 5;
    localparam int FN_TW_DATA = 6;
    localparam int FN_TW_CLK = 7;
    localparam int FN_SB_TX = 8;
    localparam int FN_SB_RX = 9;
    localparam int FN_ARR0 = 10;
    localparam int FN_ARR_CLK = 16;
    localparam int FN_CMP_A = 17;
    localparam int FN_TMR_A = 20;
    localparam int FN_CLK_OUT = 32;
    localparam int FN_CONV_A = 33;
    localparam int FN_CONV_C = 34;
    // functions that only listen to their pin
    localparam logic [34:0] FN_INPUT = 35'h6_3ff1_0222;
    // pins given up to the memory interface when reserved
    localparam int MEM_ALE = 5;
    localparam int MEM_RD = 6;
    localparam int MEM_WR = 7;
    // analog pins that are still allocated
    localparam int ANA_KEEP0 = 16;
    localparam int ANA_KEEP1 = 17;
endpackage

// file: src/ppc_pin_cell.sv
/*
 * One port pin output stage: picks source, gates drivers, pullup.
 * Assumes all inputs come from logic on clk.
 */
`timescale 1ns/1ps
module ppc_pin_cell (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic xbar_en,
    input wire logic claimed,
    input wire logic fn_val,
    input wire logic fn_drv,
    input wire logic fn_input,
    input wire logic force_od,
    input wire logic latch,
    input wire logic push_pull,
    input wire logic memif_take,
    input wire logic memif_val,
    input wire logic memif_drv,
    input wire logic weak_pud,
    input wire logic analog,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_pullup
);
    logic val;
    logic want;
    logic oe_nxt;

    always_comb begin
        if (memif_take) begin
            val = memif_val;
            want = memif_drv;
        end else if (claimed) begin
            val = fn_val;
            want = fn_drv & ~fn_input; // R13
        end else begin
            val = latch; // R7 R8
            want = 1'b1;
        end
        // open-drain only pulls low; high is left to the pullup
        oe_nxt = xbar_en & want & ((push_pull & ~force_od) | ~val);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 1'b1;
            pin_oe <= 1'b0;
            pin_pullup <= 1'b1;
        end else begin
            pin_out <= val;
            pin_oe <= oe_nxt; // R12 R15 R20 R21
            pin_pullup <= ~weak_pud & ~analog & ~(oe_nxt & ~val);
        end
    end
endmodule

// file: src/ppc_crossbar.sv
/*
 * Priority pin crossbar for ports 0..3 with port data latches.
 * Assumes config and peripheral signals come from logic on clk;
 * pin_in is asynchronous and is synchronised here.
 */
// How it works
// R1 - free pins handed out from first upward
// R2 - functions served in fixed priority order
// R3 - only enabled functions get pins
// R4 - serial port a sits on pins 0,1
// R5 - disabled function takes no position
// R6 - serial functions get all signals together
// R7 - unclaimed pins are latch-driven general I/O
// R8 - claimed pin ignores latch writes
// R9 - normal read returns pin level
// R10 - modify reads return latch contents
// R11 - allocation only with global enable set
// R12 - global enable low turns drivers off
// R13 - function input pins never driven
// R14 - latches writable per byte and bit
// R15 - open-drain or push-pull, weak pullup
// R16 - memory interface overrides pins while busy
// R17 - software sets config before peripherals
// R18 - analog pins skipped except port2 bits 0,1
// R19 - memory reserve skips strobe pins
// R20 - mode bit 1 push-pull, reset open-drain
// R21 - two-wire and mode0 receive open-drain
// R22 - three-wire mode gives select no pin
`timescale 1ns/1ps
module ppc_crossbar (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] pin_alloc_cfg_a,
    input wire logic [7:0] pin_alloc_cfg_b,
    input wire logic [7:0] pin_alloc_cfg_c,
    input wire logic [7:0] pin_alloc_cfg_d,
    input wire logic sync_serial_three_wire,
    input wire logic serial_port_a_mode0,
    input wire logic serial_port_b_mode0,
    input wire logic [31:0] output_mode_bits,
    input wire logic [31:0] input_mode_bits,
    input wire logic memif_muxed,
    input wire logic memif_busy,
    input wire logic memif_on_low,
    input wire logic [31:0] memif_pin_mask,
    input wire logic [31:0] memif_val,
    input wire logic [31:0] memif_drv,
    input wire logic port_wr_byte,
    input wire logic port_wr_bit,
    input wire logic [1:0] port_wr_sel,
    input wire logic [2:0] port_wr_idx,
    input wire logic [7:0] port_wr_data,
    input wire logic port_rd,
    input wire logic port_rd_rmw,
    input wire logic port_rd_bit,
    input wire logic [1:0] port_rd_sel,
    input wire logic [2:0] port_rd_idx,
    output logic [7:0] port_rd_data,
    input wire logic [34:0] fn_out,
    input wire logic [34:0] fn_drv,
    output logic [34:0] fn_in,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pin_pullup
);
    logic [7:0] cfg_a_r;
    logic [7:0] cfg_b_r;
    logic [7:0] cfg_c_r;
    logic [7:0] cfg_d_r;
    logic three_wire_r;
    logic crossbar_global_enable_r;
    logic [34:0] fn_en;
    logic [31:0] skip;
    logic [5:0] fn_rank [35];
    logic [5:0] pin_slot [32];
    logic [5:0] cnt;
    logic [5:0] fn_cnt;
    logic [31:0] claimed_nxt;
    logic [5:0] fn_nxt [32];
    logic [31:0] pin_claimed_r;
    logic [5:0] pin_fn_r [32];
    logic [31:0] pin_meta_r;
    logic [31:0] pin_sync_r;
    logic [31:0] pin_level;
    logic [31:0] analog;
    logic [31:0] latch_r;
    logic [34:0] fn_assigned;
    logic [34:0] fn_level;
    logic [31:0] cell_val;
    logic [31:0] cell_drv;
    logic [31:0] cell_input;
    logic [31:0] force_od;
    logic [31:0] memif_take;
    logic [7:0] rd_pins;
    logic [7:0] rd_latch;
    logic [7:0] rd_byte;

    // config sampled once so map and gate change together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_a_r <= ppc_pkg::CFG_RST;
            cfg_b_r <= ppc_pkg::CFG_RST;
            cfg_c_r <= ppc_pkg::CFG_RST;
            cfg_d_r <= ppc_pkg::CFG_RST;
            three_wire_r <= 1'b0;
            crossbar_global_enable_r <= 1'b0;
        end else begin
            cfg_a_r <= pin_alloc_cfg_a;
            cfg_b_r <= pin_alloc_cfg_b;
            cfg_c_r <= pin_alloc_cfg_c;
            cfg_d_r <= pin_alloc_cfg_d;
            three_wire_r <= sync_serial_three_wire;
            crossbar_global_enable_r <= pin_alloc_cfg_c[ppc_pkg::C_XBAR];
        end
    end

    // one enable per function slot; serial blocks share one bit
    always_comb begin
        fn_en = '0;
        fn_en[1:0] = {2{cfg_a_r[ppc_pkg::A_SA]}}; // R3 R6
        fn_en[4:2] = {3{cfg_a_r[ppc_pkg::A_SS]}}; // R6
        fn_en[ppc_pkg::FN_SS_SEL] = cfg_a_r[ppc_pkg::A_SS]
            & ~three_wire_r; // R22
        fn_en[7:6] = {2{cfg_a_r[ppc_pkg::A_TW]}}; // R6
        fn_en[9:8] = {2{cfg_c_r[ppc_pkg::C_SB]}}; // R6
        for (int k = 0; k < 6; k++) begin
            fn_en[ppc_pkg::FN_ARR0 + k] =
                (cfg_a_r[ppc_pkg::A_ARR_LO +: 3] > 3'(k)); // R3
        end
        fn_en[ppc_pkg::FN_ARR_CLK] = cfg_a_r[ppc_pkg::A_ECLK];
        fn_en[17] = cfg_a_r[ppc_pkg::A_CMPA];
        fn_en[18] = cfg_b_r[ppc_pkg::B_CMPB];
        fn_en[19] = cfg_d_r[ppc_pkg::D_CMPC];
        fn_en[20] = cfg_b_r[ppc_pkg::B_TMRA];
        fn_en[21] = cfg_b_r[ppc_pkg::B_IRQA];
        fn_en[22] = cfg_b_r[ppc_pkg::B_TMRB];
        fn_en[23] = cfg_b_r[ppc_pkg::B_IRQB];
        fn_en[24] = cfg_b_r[ppc_pkg::B_TMRC];
        fn_en[25] = cfg_b_r[ppc_pkg::B_TMRCX];
        fn_en[26] = cfg_d_r[ppc_pkg::D_TMRD];
        fn_en[27] = cfg_d_r[ppc_pkg::D_TMRDX];
        fn_en[28] = cfg_c_r[ppc_pkg::C_TMRE];
        fn_en[29] = cfg_c_r[ppc_pkg::C_TMREX];
        fn_en[ppc_pkg::FN_CLK_OUT] = cfg_b_r[ppc_pkg::B_CLKO];
        fn_en[ppc_pkg::FN_CONV_A] = cfg_c_r[ppc_pkg::C_CONVA];
        fn_en[ppc_pkg::FN_CONV_C] = cfg_d_r[ppc_pkg::D_CONVC];
        // slots 30,31 are unused spare positions, never enabled
    end

    // analog mode exists on ports 1..3 only
    assign analog = ~input_mode_bits & 32'hffffff00;

    always_comb begin
        skip = analog; // R18
        skip[ppc_pkg::ANA_KEEP0] = 1'b0; // R18
        skip[ppc_pkg::ANA_KEEP1] = 1'b0; // R18
        if (cfg_c_r[ppc_pkg::C_MEMLO]) begin
            skip[ppc_pkg::MEM_WR] = 1'b1; // R19
            skip[ppc_pkg::MEM_RD] = 1'b1; // R19
            skip[ppc_pkg::MEM_ALE] = memif_muxed; // R19
        end
    end

    // position k among enabled functions meets k-th free pin
    always_comb begin
        fn_cnt = 6'h00;
        for (int f = 0; f < ppc_pkg::FNS; f++) begin
            fn_rank[f] = fn_cnt;
            if (fn_en[f]) begin
                fn_cnt = fn_cnt + 6'h01; // R2 R5
            end
        end
    end

    always_comb begin
        cnt = 6'h00;
        for (int p = 0; p < ppc_pkg::PINS; p++) begin
            pin_slot[p] = cnt;
            if (!skip[p]) begin
                cnt = cnt + 6'h01; // R1
            end
        end
    end

    always_comb begin
        for (int p = 0; p < ppc_pkg::PINS; p++) begin
            claimed_nxt[p] = 1'b0;
            fn_nxt[p] = 6'h00;
            for (int f = 0; f < ppc_pkg::FNS; f++) begin
                if (fn_en[f] && !skip[p] &&
                    fn_rank[f] == pin_slot[p]) begin
                    claimed_nxt[p] = crossbar_global_enable_r; // R11
                    fn_nxt[p] = 6'(f); // R1 R4
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_claimed_r <= '0;
            for (int p = 0; p < ppc_pkg::PINS; p++) begin
                pin_fn_r[p] <= 6'h00;
            end
        end else begin
            pin_claimed_r <= claimed_nxt;
            for (int p = 0; p < ppc_pkg::PINS; p++) begin
                pin_fn_r[p] <= fn_nxt[p];
            end
        end
    end

    // pins are asynchronous; two stages before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // analog pins have no digital input path
    assign pin_level = pin_sync_r & ~analog;

    always_comb begin
        for (int f = 0; f < ppc_pkg::FNS; f++) begin
            fn_assigned[f] = 1'b0;
            fn_level[f] = 1'b1;
            for (int p = 0; p < ppc_pkg::PINS; p++) begin
                if (pin_claimed_r[p] && pin_fn_r[p] == 6'(f)) begin
                    fn_assigned[f] = 1'b1;
                    fn_level[f] = pin_level[p];
                end
            end
        end
    end

    // an unplaced function sees an idle high line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fn_in <= '1;
        end else begin
            fn_in <= fn_level; // R5
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= ppc_pkg::LATCH_RST;
        end else if (port_wr_byte) begin
            latch_r[{port_wr_sel, 3'h0} +: 8] <= port_wr_data; // R14
        end else if (port_wr_bit) begin
            latch_r[{port_wr_sel, port_wr_idx}] <= port_wr_data[0]; // R14
        end
    end

    assign rd_pins = pin_level[{port_rd_sel, 3'h0} +: 8];
    assign rd_latch = latch_r[{port_rd_sel, 3'h0} +: 8];
    assign rd_byte = port_rd_rmw ? rd_latch : rd_pins; // R9 R10

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_rd_data <= 8'h00;
        end else if (port_rd) begin
            if (port_rd_bit) begin
                port_rd_data <= {7'h00, rd_byte[port_rd_idx]};
            end else begin
                port_rd_data <= rd_byte;
            end
        end
    end

    // per-pin view of the function mapped onto it
    always_comb begin
        for (int p = 0; p < ppc_pkg::PINS; p++) begin
            cell_val[p] = fn_out[pin_fn_r[p]]; // R8
            cell_drv[p] = fn_drv[pin_fn_r[p]];
            cell_input[p] = ppc_pkg::FN_INPUT[pin_fn_r[p]]
                & ~(pin_fn_r[p] == 6'(ppc_pkg::FN_SA_RX)
                    & serial_port_a_mode0)
                & ~(pin_fn_r[p] == 6'(ppc_pkg::FN_SB_RX)
                    & serial_port_b_mode0); // R13
            force_od[p] = pin_claimed_r[p] & (
                pin_fn_r[p] == 6'(ppc_pkg::FN_TW_DATA) |
                pin_fn_r[p] == 6'(ppc_pkg::FN_TW_CLK) |
                (pin_fn_r[p] == 6'(ppc_pkg::FN_SA_RX)
                    & serial_port_a_mode0) |
                (pin_fn_r[p] == 6'(ppc_pkg::FN_SB_RX)
                    & serial_port_b_mode0)); // R21
        end
    end

    assign memif_take = {32{memif_busy & memif_on_low}}
        & memif_pin_mask; // R16

    for (genvar p = 0; p < ppc_pkg::PINS; p++) begin : g_pin
        ppc_pin_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .xbar_en(crossbar_global_enable_r),
            .claimed(pin_claimed_r[p]),
            .fn_val(cell_val[p]),
            .fn_drv(cell_drv[p]),
            .fn_input(cell_input[p]),
            .force_od(force_od[p]),
            .latch(latch_r[p]),
            .push_pull(output_mode_bits[p]),
            .memif_take(memif_take[p]),
            .memif_val(memif_val[p]),
            .memif_drv(memif_drv[p]),
            .weak_pud(cfg_c_r[ppc_pkg::C_PUD]),
            .analog(analog[p]),
            .pin_out(pin_out[p]),
            .pin_oe(pin_oe[p]),
            .pin_pullup(pin_pullup[p])
        );
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [31:0] in_claim;
    assign in_claim = pin_claimed_r & cell_input & ~memif_take;

    sequence s_xbar_off;
        !crossbar_global_enable_r;
    endsequence

    sequence s_cfg_seen;
        pin_alloc_cfg_c[ppc_pkg::C_XBAR] ##1 crossbar_global_enable_r;
    endsequence

    a_xbar_gate: assert property ( // R12
        s_xbar_off |=> pin_oe == '0)
        else $error("drivers on while crossbar disabled");

    a_no_alloc_off: assert property ( // R11
        s_xbar_off |=> pin_claimed_r == '0)
        else $error("pins claimed while crossbar disabled");

    a_serial_a_fixed: assert property ( // R4
        (s_cfg_seen ##0 cfg_a_r[ppc_pkg::A_SA]) |=>
        pin_claimed_r[1:0] == 2'b11 &&
        pin_fn_r[0] == 6'(ppc_pkg::FN_SA_TX) &&
        pin_fn_r[1] == 6'(ppc_pkg::FN_SA_RX))
        else $error("serial port a not on pins 0 and 1");

    a_contig_order: assert property ( // R1
        ($past(skip) == '0) |->
        (pin_claimed_r & (pin_claimed_r + 32'h1)) == '0)
        else $error("claimed pins not contiguous from pin 0");

    a_disabled_free: assert property ( // R5
        $stable(fn_en) |=> (fn_assigned & ~$past(fn_en)) == '0)
        else $error("disabled function holds a pin");

    a_select_dropped: assert property ( // R22
        three_wire_r |=> !fn_assigned[ppc_pkg::FN_SS_SEL])
        else $error("select placed in three-wire mode");

    a_input_undriven: assert property ( // R13
        ##1 (pin_oe & $past(in_claim)) == '0)
        else $error("function input pin driven");

    a_od_forced: assert property ( // R21
        ##1 (pin_oe & pin_out & $past(force_od)) == '0)
        else $error("forced open-drain pin driven high");

    a_rmw_latch: assert property ( // R10
        port_rd && port_rd_rmw && !port_rd_bit |=>
        port_rd_data == $past(rd_latch))
        else $error("modify read did not return latch");

    a_pin_read: assert property ( // R9
        port_rd && !port_rd_rmw && !port_rd_bit |=>
        port_rd_data == $past(rd_pins))
        else $error("read did not return pin level");

    a_latch_write: assert property ( // R14
        port_wr_bit && !port_wr_byte |=>
        latch_r[$past({port_wr_sel, port_wr_idx})] ==
        $past(port_wr_data[0]))
        else $error("bit write lost");
endmodule

// file: verification/ppc_board.sv
/*
 * Board-side model of the 32 port pins: resolves each wire from the
 * block's drivers, its weak pullups and an external driver.
 * Assumes the bench drives ext_drv and ext_val just after clk edges.
 */
`timescale 1ns/1ps
module ppc_board (
    input wire logic clk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pullup,
    input wire logic [31:0] ext_drv,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_level
);
    logic [31:0] float_r;

    // a wire nobody holds wanders every cycle, so no check can lean on it
    always @(posedge clk) begin
        float_r <= (float_r === 32'hxxxxxxxx) ? 32'h55555555 : ~float_r;
    end

    // the block's own driver wins over the board
    always_comb begin
        for (int p = 0; p < 32; p++) begin
            if (pin_oe[p] === 1'b1) begin
                pin_level[p] = pin_out[p];
            end else if (ext_drv[p]) begin
                pin_level[p] = ext_val[p];
            end else if (pin_pullup[p] === 1'b1) begin
                pin_level[p] = 1'b1;
            end else begin
                pin_level[p] = float_r[p];
            end
        end
    end
endmodule

// file: verification/priority_pin_crossbar_test.sv
/*
 * Self-checking bench for the port crossbar: config tables, port
 * reads and writes, pin levels through a board model.
 * Assumes ppc_crossbar as top and ppc_board on its pins.
 */
`timescale 1ns/1ps
module priority_pin_crossbar_test;
    logic clk, rst_n;
    logic [7:0] cfg_a, cfg_b, cfg_c, cfg_d;
    logic three_wire, mode0_a, mode0_b, muxed, mbusy, mlow;
    logic [31:0] omode, imode, mmask, mval, mdrv, ext_drv, ext_val;
    logic wr_byte, wr_bit, rd, rd_rmw, rd_bit;
    logic [1:0] wr_sel, rd_sel;
    logic [2:0] wr_idx, rd_idx;
    logic [7:0] wr_data, rd_data, got;
    logic [34:0] fn_out, fn_drv, fn_in;
    logic [31:0] pin_in, pin_out, pin_oe, pin_pullup;
    int err_total, samples_checked;

    ppc_crossbar u_ppc_crossbar (
        .clk(clk), .rst_n(rst_n),
        .pin_alloc_cfg_a(cfg_a), .pin_alloc_cfg_b(cfg_b),
        .pin_alloc_cfg_c(cfg_c), .pin_alloc_cfg_d(cfg_d),
        .sync_serial_three_wire(three_wire),
        .serial_port_a_mode0(mode0_a), .serial_port_b_mode0(mode0_b),
        .output_mode_bits(omode), .input_mode_bits(imode),
        .memif_muxed(muxed), .memif_busy(mbusy), .memif_on_low(mlow),
        .memif_pin_mask(mmask), .memif_val(mval), .memif_drv(mdrv),
        .port_wr_byte(wr_byte), .port_wr_bit(wr_bit),
        .port_wr_sel(wr_sel), .port_wr_idx(wr_idx),
        .port_wr_data(wr_data), .port_rd(rd), .port_rd_rmw(rd_rmw),
        .port_rd_bit(rd_bit), .port_rd_sel(rd_sel), .port_rd_idx(rd_idx),
        .port_rd_data(rd_data), .fn_out(fn_out), .fn_drv(fn_drv),
        .fn_in(fn_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup)
    );

    ppc_board u_ppc_board (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_drv(ext_drv), .ext_val(ext_val),
        .pin_level(pin_in)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e,
                         input string what);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask

    // every task called from the main sequence starts and ends 1 ns after a rising edge
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_port(input logic [1:0] sel, input logic [7:0] d);
        wr_sel = sel;
        wr_data = d;
        wr_byte = 1'b1;
        wait_n(1);
        wr_byte = 1'b0;
        wait_n(1);
    endtask

    task automatic wr_pin(input logic [1:0] sel, input logic [2:0] idx,
                          input logic v);
        wr_sel = sel;
        wr_idx = idx;
        wr_data = {7'h00, v};
        wr_bit = 1'b1;
        wait_n(1);
        wr_bit = 1'b0;
        wait_n(1);
    endtask

    task automatic rd_port(input logic [1:0] sel, input logic rmw,
                           input logic bm, input logic [2:0] idx);
        rd_sel = sel;
        rd_rmw = rmw;
        rd_bit = bm;
        rd_idx = idx;
        rd = 1'b1;
        wait_n(1);
        rd = 1'b0;
        got = rd_data;
        wait_n(1);
    endtask

    // crossbar config goes in before any peripheral drives its pin
    task automatic set_cfg(input logic [7:0] a, input logic [7:0] b,
                           input logic [7:0] c, input logic [7:0] d,
                           input logic tw, input logic mx,
                           input logic [31:0] im);
        fn_out = '0;
        cfg_a = a;
        cfg_b = b;
        cfg_c = c;
        cfg_d = d;
        three_wire = tw;
        muxed = mx;
        imode = im;
        wait_n(5);
    endtask

    // the pin is claimed, so its latch is ignored and only the mapped function can lift the wire
    task automatic map_chk(input int slot, input int pin);
        fn_out = '0;
        fn_out[slot] = 1'b1;
        wait_n(4);
        check(32'(pin_in[pin]), 32'h1, "mapped pin high");
        fn_out[slot] = 1'b0;
        wait_n(4);
        check(32'(pin_in[pin]), 32'h0, "mapped pin low");
    endtask

    task automatic run_map(input logic [7:0] a, input logic [7:0] b,
                           input logic [7:0] c, input logic [7:0] d,
                           input logic tw, input logic mx,
                           input logic [31:0] im, input int slot,
                           input int pin);
        set_cfg(a, b, c, d, tw, mx, im);
        map_chk(slot, pin);
    endtask

    initial begin
        #100000;
        err_total++;
        complete_run();
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        {cfg_a, cfg_b, cfg_c, cfg_d} = '0;
        {three_wire, mode0_a, mode0_b, muxed, mbusy, mlow} = '0;
        omode = '1;
        imode = '1;
        {mmask, mval, mdrv, ext_drv, ext_val} = '0;
        {wr_byte, wr_bit, rd, rd_rmw, rd_bit} = '0;
        {wr_sel, rd_sel, wr_idx, rd_idx, wr_data} = '0;
        fn_out = '0;
        fn_drv = '1;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        wait_n(2);
        check(pin_oe, 32'h0, "oe after reset");
        rd_port(2'h3, 1'b1, 1'b0, 3'h0);
        check(32'(got), 32'hff, "latch reset");
        for (int s = 0; s < 4; s++) begin
            wr_port(2'(s), 8'h00);
        end
        set_cfg(8'h04, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, '1);
        check(pin_oe, 32'h0, "oe while crossbar off");
        run_map(8'h04, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1, 0, 0);
        run_map(8'h01, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1, 6, 0);
        fn_out[6] = 1'b1;
        wait_n(4);
        check(32'(pin_oe[0]), 32'h0, "two-wire high not driven");
        run_map(8'h07, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1, 6, 6);
        map_chk(4, 4);
        run_map(8'h07, 8'h00, 8'h10, 8'h00, 1'b1, 1'b0, '1, 6, 5);
        run_map(8'h07, 8'h00, 8'h30, 8'h00, 1'b0, 1'b1, '1, 6, 9);
        run_map(8'h07, 8'h00, 8'h30, 8'h00, 1'b0, 1'b0, '1, 6, 8);
        run_map(8'h07, 8'h00, 8'h14, 8'h00, 1'b0, 1'b0,
                32'hfffffeff, 8, 9);
        run_map(8'hb7, 8'h00, 8'h14, 8'h00, 1'b0, 1'b0,
                32'hfffcffff, 17, 16);
        map_chk(15, 15);
        run_map(8'h08, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1, 10, 0);
        run_map(8'h30, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1, 15, 5);
        run_map(8'h00, 8'h80, 8'h10, 8'h00, 1'b0, 1'b0, '1, 32, 0);
        run_map(8'h00, 8'h00, 8'h10, 8'h08, 1'b0, 1'b0, '1, 19, 0);
        // serial port a again: pin reads against latch reads
        set_cfg(8'h04, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1);
        fn_out[0] = 1'b1;
        wait_n(4);
        check(32'(pin_oe[1]), 32'h0, "receive pin driven");
        rd_port(2'h0, 1'b0, 1'b0, 3'h0);
        check(32'(got), 32'h03, "pin read");
        rd_port(2'h0, 1'b1, 1'b0, 3'h0);
        check(32'(got), 32'h00, "latch read");
        ext_drv[1] = 1'b1;
        wait_n(5);
        check(32'(fn_in[1]), 32'h0, "receive sees pin");
        rd_port(2'h0, 1'b0, 1'b0, 3'h0);
        check(32'(got), 32'h01, "pin read low rx");
        ext_drv[1] = 1'b0;
        wr_pin(2'h0, 3'h3, 1'b1);
        wait_n(4);
        rd_port(2'h0, 1'b1, 1'b1, 3'h3);
        check(32'(got[0]), 32'h1, "bit latch read");
        rd_port(2'h0, 1'b0, 1'b0, 3'h0);
        check(32'(got), 32'h0b, "gpio pin 3 high");
        fn_out[0] = 1'b0;
        wr_port(2'h0, 8'hff);
        wait_n(4);
        check(32'(pin_in[0]), 32'h0, "claimed pin ignores latch");
        rd_port(2'h0, 1'b1, 1'b0, 3'h0);
        check(32'(got), 32'hff, "latch kept");
        mode0_a = 1'b1;
        map_chk(1, 1);
        mode0_a = 1'b0;
        // open-drain and pullups on port 2, then the memory interface
        set_cfg(8'h00, 8'h00, 8'h10, 8'h00, 1'b0, 1'b0, '1);
        omode = '0;
        wr_port(2'h2, 8'h0f);
        wait_n(4);
        check(32'(pin_oe[23:16]), 32'hf0, "open-drain drive");
        check(32'(pin_pullup[23:16]), 32'h0f, "pullup off at 0");
        omode = '1;
        wait_n(4);
        check(32'(pin_oe[23:16]), 32'hff, "push-pull drive");
        mmask = 32'h00800000;
        mval = 32'h00800000;
        mdrv = 32'h00800000;
        mlow = 1'b1;
        mbusy = 1'b1;
        wait_n(4);
        check(32'(pin_in[23]), 32'h1, "memif owns pin");
        mbusy = 1'b0;
        wait_n(4);
        check(32'(pin_in[23]), 32'h0, "memif released");
        set_cfg(8'h00, 8'h00, 8'h90, 8'h00, 1'b0, 1'b0, '1);
        check(pin_pullup, 32'h0, "pullups disabled");
        complete_run();
    end
endmodule
